/* bench/tcg_tone_gen_model.sv */
// Tone generator model answering sample requests of the block
`timescale 1ns/100ps
module tcg_tone_gen_model (
  input  wire logic               clk,       // Oscillator clock
  input  wire logic               rst,       // Reset, high
  input  wire tcg_pkg::tcg_clk_type bus_clks, // Bus clocks
  input  wire logic               tone_req,  // Sample request
  input  wire logic [4:0]         tone_ridx, // Requested index
  output      logic               tone_we,   // Sample write
  output      logic [4:0]         tone_widx, // Written index
  output      logic [7:0]         tone_wdata // Written sample
);
  logic frame_prev; // Last frame clock level
  // Answer each request next cycle; tone 0 written at frame start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tone_we    <= 1'b0;
      tone_widx  <= 5'h00;
      tone_wdata <= 8'h00;
      frame_prev <= 1'b0;
    end
    else
    begin
      frame_prev <= bus_clks.frame_clk;
      tone_we    <= tone_req | (bus_clks.frame_clk & ~frame_prev);
      tone_widx  <= tone_req ? tone_ridx : 5'h00;
      tone_wdata <= 8'h40 | {3'h0, (tone_req ? tone_ridx : 5'h00)};
    end
  end
endmodule // tcg_tone_gen_model

/* bench/tcg_top_tb.sv */
// Self-checking bench for the clock and tone slot generator
`timescale 1ns/100ps
module tcg_top_tb;
  logic REF_CLK = 1'b0;             // Oscillator clock
  logic RST = 1'b1;                 // Reset
  tcg_pkg::tcg_clk_type clks;       // Bus clocks
  logic req, we, oe_n, tbl_we = 1'b0; // Strobes
  logic [4:0] ridx, widx;           // Tone indices
  logic [7:0] wdata, bdata;         // Samples
  logic [7:0] tbl_addr = 8'h00;     // Table address
  tcg_pkg::tcg_entry_type tbl_entry = '0; // Table entry
  int fail_count = 0;               // Mismatches
  int checked = 0;                  // Comparisons
  always #50 REF_CLK = ~REF_CLK;
  tcg_top tcg_top_i (.REF_CLK(REF_CLK), .RST(RST), .BUS_CLKS(clks),
    .TONE_REQ(req), .TONE_RIDX(ridx), .TONE_WE(we), .TONE_WIDX(widx),
    .TONE_WDATA(wdata), .TBL_WE(tbl_we), .TBL_ADDR(tbl_addr),
    .TBL_ENTRY(tbl_entry), .BUS_DATA(bdata), .BUS_OE_N(oe_n));
  tcg_tone_gen_model tcg_tone_gen_model_i (.clk(REF_CLK), .rst(RST),
    .bus_clks(clks), .tone_req(req), .tone_ridx(ridx), .tone_we(we),
    .tone_widx(widx), .tone_wdata(wdata));
  // Compare and count
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d, failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Stop on the negedge where the frame clock first shows high
  task automatic wait_frame();
    logic prev;
    prev = 1'b1;
    for (int n = 0; n < 3000; n++)
    begin
      @(negedge REF_CLK);
      if (clks.frame_clk === 1'b1 && prev === 1'b0)
        return;
      prev = clks.frame_clk;
    end
  endtask
  // Periods of the three bus clocks, high times of the middle and frame clocks
  task automatic clock_test();
    int t_b, t_m, t_f, hi_m, hi_f;
    tcg_pkg::tcg_clk_type p;
    t_b = 0; t_m = 0; t_f = 0; hi_m = 0; hi_f = 0;
    wait_frame();
    p = clks;
    for (int n = 1; n <= 2560; n++)
    begin
      hi_m += (n <= 128) ? int'(p.mid_clk) : 0;
      hi_f += int'(p.frame_clk);
      @(negedge REF_CLK);
      if (clks.bit_clk && !p.bit_clk && t_b == 0) t_b = n;
      if (clks.mid_clk && !p.mid_clk && t_m == 0) t_m = n;
      if (clks.frame_clk && !p.frame_clk && t_f == 0) t_f = n;
      p = clks;
    end
    cmp(16'(t_b), 16'h000A);
    cmp(16'(t_m), 16'h0080);
    cmp(16'(t_f), 16'h0A00);
    cmp(16'(hi_m), 16'h0040);
    cmp(16'(hi_f), 16'h0500);
  endtask
  // Requests 0..23, one per slot start, over one frame
  task automatic request_test();
    int cnt;
    cnt = 0;
    wait_frame();
    for (int n = 0; n < 2560; n++)
    begin
      if (req === 1'b1)
      begin
        cnt++;
        cmp(16'(n % 10), 16'h0000);
        cmp(16'(ridx), 16'(n / 10));
      end
      @(negedge REF_CLK);
    end
    cmp(16'(cnt), 16'h0018);
  endtask
  task automatic tbl_write(input logic [7:0] a, input logic v,
                           input logic [4:0] t);
    @(posedge REF_CLK);
    tbl_we    <= 1'b1;
    tbl_addr  <= a;
    tbl_entry <= '{valid: v, tone: t};
    @(posedge REF_CLK);
    tbl_we    <= 1'b0;
  endtask
  // Slot outputs: valid, invalid, out-of-range tone, wrap slots
  task automatic slot_test();
    logic [7:0] s [6] = '{8'h00, 8'h05, 8'h07, 8'h09, 8'h64, 8'hFF};
    logic [5:0] e [6] = '{6'h2C, 6'h37, 6'h3E, 6'h00, 6'h03, 6'h20};
    int cur;
    for (int i = 0; i < 6; i++)
      if (i != 3) tbl_write(s[i], e[i][5], e[i][4:0]);
    wait_frame();
    wait_frame();
    cur = 0;
    for (int i = 0; i < 6; i++)
    begin
      repeat (10 * int'(s[i]) + 5 - cur) @(negedge REF_CLK);
      cur = 10 * int'(s[i]) + 5;
      if (e[i][5] && e[i][4:0] < 5'd24)
      begin
        cmp(16'(oe_n), 16'h0000);
        cmp(16'(bdata), 16'(8'h40 | {3'h0, e[i][4:0]}));
      end
      else
        cmp(16'(oe_n), 16'h0001);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    clock_test();
    request_test();
    slot_test();
    give_verdict();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge REF_CLK);
    fail_count++;
    give_verdict();
  end
endmodule // tcg_top_tb

/* design/tcg_cfg.svh */
// Timing counts and table geometry for the TDM clock and tone generator
`ifndef TCG_CFG_SVH
`define TCG_CFG_SVH
`define TCG_DIV_BIT    10
`define TCG_DIV_FRAME  2560
`define TCG_DIV_MID    128
`define TCG_NUM_TONES  24
`define TCG_NUM_SLOTS  256
`define TCG_SAMPLE_W   8
`define TCG_FETCH_SUB  4'h7
`define TCG_SLOT_LAST  4'h9
`define TCG_BIT_HALF   4'h5
`define TCG_MID_LAST   7'h7F
`define TCG_MID_HALF   7'h40
`define TCG_FRM_LAST   12'h09FF
`define TCG_FRM_HALF   12'h0500
`endif

/* design/tcg_pkg.sv */
// Types shared by the TDM clock and tone generator
package tcg_pkg;
  // One time slot table entry
  typedef struct packed {
    logic       valid;  // Slot carries a tone
    logic [4:0] tone;   // Tone index
  } tcg_entry_type;
  // Bus clock bundle
  typedef struct packed {
    logic bit_clk;      // 2.048 MHz
    logic mid_clk;      // 160 kHz
    logic frame_clk;    // 8 kHz
  } tcg_clk_type;
endpackage

/* design/tcg_top.sv */
// TDM bus clock divider, tone memory and time slot table
`timescale 1ns/100ps
`include "tcg_cfg.svh"
module tcg_top #(
  parameter int SAMPLE_W  = `TCG_SAMPLE_W,   // Tone sample width
  parameter int NUM_TONES = `TCG_NUM_TONES   // Tones kept in memory
) (
  input  wire logic                REF_CLK,    // Oscillator clock
  input  wire logic                RST,        // Power-on reset, high
  output      tcg_pkg::tcg_clk_type BUS_CLKS,  // Bus clocks out
  output      logic                TONE_REQ,   // Sample request pulse
  output      logic [4:0]          TONE_RIDX,  // Requested tone index
  input  wire logic                TONE_WE,    // Sample write strobe
  input  wire logic [4:0]          TONE_WIDX,  // Written tone index
  input  wire logic [SAMPLE_W-1:0] TONE_WDATA, // Written sample
  input  wire logic                TBL_WE,     // Table write strobe
  input  wire logic [7:0]          TBL_ADDR,   // Table entry address
  input  wire tcg_pkg::tcg_entry_type TBL_ENTRY, // Table entry data
  output      logic [SAMPLE_W-1:0] BUS_DATA,   // Slot sample out
  output      logic                BUS_OE_N    // Low while driving
);

  // Refuse parameters the 5-bit tone index cannot address;
  // 32 tones would wrap the 5-bit limit compare to zero
  if (NUM_TONES < 1 || NUM_TONES > 31 || SAMPLE_W < 1)
  begin : g_bad_param
    $error("tcg_top: unsupported NUM_TONES or SAMPLE_W");
  end

  logic [3:0]  sub_cnt;       // Oscillator cycle within slot
  logic [6:0]  mid_cnt;       // 160 kHz divider
  logic [11:0] frame_cnt;     // Oscillator cycle within frame
  logic [7:0]  slot_cnt;      // Current bus slot
  logic [4:0]  tone_cnt;      // Tone counter
  logic [SAMPLE_W-1:0] tone_mem [NUM_TONES];       // Tone memory
  tcg_pkg::tcg_entry_type tbl [`TCG_NUM_SLOTS];    // Slot table
  tcg_pkg::tcg_entry_type entry_q;  // Fetched entry of next slot
  logic [SAMPLE_W-1:0] samp_q;      // Fetched sample of next slot
  logic                drive_q;     // Next slot is driven

  // Decodes of the divider state, the tone clock strobes
  wire slot_end   = (sub_cnt == `TCG_SLOT_LAST);
  wire frame_wrap = (frame_cnt == `TCG_FRM_LAST);
  wire fetch_now  = (sub_cnt == `TCG_FETCH_SUB);
  wire sample_now = (sub_cnt == `TCG_FETCH_SUB + 4'h1);
  wire tone_left  = (tone_cnt < 5'(NUM_TONES));
  // Another tone remains after the current one
  wire tone_more  = (tone_cnt < 5'(NUM_TONES - 1));
  // Frame start asks for tone 0, later slot starts the next tone
  wire       next_req  = slot_end && (frame_wrap || tone_more);
  wire [4:0] next_ridx = frame_wrap ? 5'h00 : tone_cnt + 5'h01;
  wire [7:0] next_slot = slot_cnt + 8'h01;
  wire entry_ok   = entry_q.valid && (entry_q.tone < 5'(NUM_TONES));
  wire [SAMPLE_W-1:0] mem_at_entry =
    entry_ok ? tone_mem[entry_q.tone] : '0;
  wire [3:0]  next_sub   = slot_end ? 4'h0 : sub_cnt + 4'h1;
  wire [6:0]  next_mid   = mid_cnt + 7'h01;
  wire [11:0] next_frame = frame_wrap ? 12'h000 : frame_cnt + 12'h001;

  // Free-running dividers; only power-on reset touches them
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      sub_cnt   <= 4'h0;
      mid_cnt   <= 7'h00;
      frame_cnt <= 12'h000;
    end
    else
    begin
      sub_cnt   <= next_sub;
      mid_cnt   <= next_mid;
      frame_cnt <= next_frame;
    end
  end

  // Registered bus clock drivers, roughly half duty each
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      // Counts rest at zero, inside the high phase of every clock;
      // a low reset level would give a short first pulse
      BUS_CLKS <= 3'b111;
    else
    begin
      BUS_CLKS.bit_clk   <= (next_sub < `TCG_BIT_HALF);
      BUS_CLKS.mid_clk   <= (next_mid < `TCG_MID_HALF);
      BUS_CLKS.frame_clk <= (next_frame < `TCG_FRM_HALF);
    end
  end

  // Slot and tone counters locked to the frame by tone clock strobes
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      slot_cnt <= 8'h00;
      tone_cnt <= 5'h00;
    end
    else if (frame_wrap)
    begin
      slot_cnt <= 8'h00;
      tone_cnt <= 5'h00;
    end
    else if (slot_end)
    begin
      slot_cnt <= next_slot;
      tone_cnt <= tone_left ? tone_cnt + 5'h01 : tone_cnt;
    end
  end

  // One request per tone per frame, tone 0 excepted in the first frame after reset, at the first cycle of a slot
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      TONE_REQ  <= 1'b0;
      TONE_RIDX <= 5'h00;
    end
    else
    begin
      TONE_REQ  <= next_req;
      TONE_RIDX <= next_ridx;
    end
  end

  // Tone memory: one address per tone, written by the generator
  for (genvar t = 0; t < NUM_TONES; t++)
  begin : g_tone
    always_ff @(posedge REF_CLK or posedge RST)
    begin
      if (RST)
        tone_mem[t] <= '0;
      else if (TONE_WE && TONE_WIDX == 5'(t))
        tone_mem[t] <= TONE_WDATA;
    end
  end

  // Slot table: processor side port, all entries invalid at reset
  for (genvar s = 0; s < `TCG_NUM_SLOTS; s++)
  begin : g_slot
    always_ff @(posedge REF_CLK or posedge RST)
    begin
      if (RST)
        tbl[s] <= '0;
      else if (TBL_WE && TBL_ADDR == 8'(s))
        tbl[s] <= TBL_ENTRY;
    end
  end

  // Fetch pipeline, started ahead of the slot boundary
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      entry_q <= '0;
      samp_q  <= '0;
      drive_q <= 1'b0;
    end
    else
    begin
      if (fetch_now)
        entry_q <= tbl[next_slot];
      if (sample_now)
      begin
        samp_q  <= mem_at_entry;
        drive_q <= entry_ok;
      end
    end
  end

  // Bus output changes only at the slot boundary
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      BUS_DATA <= '0;
      BUS_OE_N <= 1'b1;
    end
    else if (slot_end)
    begin
      BUS_DATA <= samp_q;
      BUS_OE_N <= !drive_q;
    end
  end

  // Helper count of requests within the current frame
  logic [5:0] req_seen;
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      req_seen <= 6'h00;
    else if (frame_wrap)
      req_seen <= 6'h00;
    else if (TONE_REQ)
      req_seen <= req_seen + 6'h01;
  end
  logic first_frame;   // Before the first full frame has passed
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      first_frame <= 1'b1;
    else if (frame_wrap)
      first_frame <= 1'b0;
  end

  // Checks of dividers, tone requests, table and slot output
  // Invalid entry seen at the fetch edge of the next slot
  sequence s_fetch_invalid;
    fetch_now && !tbl[next_slot].valid;
  endsequence
  // Bus released once that slot has begun
  sequence s_slot_idle;
    ##3 (sub_cnt == 4'h0) && BUS_OE_N;
  endsequence

  // Slot divider wraps every ten oscillator cycles
  a_slot_wrap: assert property (@(posedge REF_CLK) disable iff (RST)
    slot_end |=> sub_cnt == 4'h0 ##9 slot_end)
    else $error("slot divider not ten cycles");
  // Slot counter ends each frame on its last slot
  a_frame_align: assert property (@(posedge REF_CLK) disable iff (RST)
    frame_wrap |-> slot_end && slot_cnt == 8'hFF ##1 slot_cnt == 8'h00)
    else $error("slot counter not aligned to frame");
  // Middle clock divider wraps after 128 cycles
  a_mid_wrap: assert property (@(posedge REF_CLK) disable iff (RST)
    mid_cnt == `TCG_MID_LAST |=> mid_cnt == 7'h00)
    else $error("160 kHz divider not 128");
  // Bit clock five cycles high, five low
  a_bit_clk_duty: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(BUS_CLKS.bit_clk) |-> BUS_CLKS.bit_clk [*5] ##1 !BUS_CLKS.bit_clk [*5]
      ##1 BUS_CLKS.bit_clk)
    else $error("bit clock not 2.048 MHz");
  // Frame clock rises only at the frame wrap
  a_frame_clk_edge: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(BUS_CLKS.frame_clk) |-> $past(frame_wrap))
    else $error("frame clock rise off frame start");
  // Request count in each frame after the first equals NUM_TONES
  a_tone_per_frame: assert property (@(posedge REF_CLK) disable iff (RST)
    frame_wrap && !first_frame |-> req_seen == 6'(NUM_TONES))
    else $error("wrong tone requests per frame");
  // Generator write lands at its own tone address
  a_tone_store: assert property (@(posedge REF_CLK) disable iff (RST)
    TONE_WE && TONE_WIDX < 5'(NUM_TONES) |=>
      tone_mem[$past(TONE_WIDX)] == $past(TONE_WDATA))
    else $error("tone sample not stored");
  // Processor write lands in the addressed entry
  a_table_store: assert property (@(posedge REF_CLK) disable iff (RST)
    TBL_WE |=> tbl[$past(TBL_ADDR)] == $past(TBL_ENTRY))
    else $error("table entry not stored");
  // Slot with an invalid entry leaves the bus undriven
  a_invalid_idle: assert property (@(posedge REF_CLK) disable iff (RST)
    s_fetch_invalid |-> s_slot_idle)
    else $error("invalid slot driven");
  // Valid slot carries the sample fetched for it
  a_slot_sample: assert property (@(posedge REF_CLK) disable iff (RST)
    sample_now && entry_ok |-> ##2 !BUS_OE_N &&
      BUS_DATA == $past(mem_at_entry, 2))
    else $error("slot sample wrong");

  // Requested index always addresses the tone memory
  a_req_range: assert property (@(posedge REF_CLK) disable iff (RST)
    TONE_REQ |-> TONE_RIDX < 5'(NUM_TONES))
    else $error("tone request index out of range");

  // Nine quiet cycles after each request
  sequence s_req_gap;
    !TONE_REQ [*8] ##1 !TONE_REQ;
  endsequence
  // Requests never come closer than one slot apart
  a_req_gap: assert property (@(posedge REF_CLK) disable iff (RST)
    TONE_REQ |=> s_req_gap)
    else $error("tone requests too close");

  // Each frame restarts the requests with tone 0
  a_frame_first_req: assert property (@(posedge REF_CLK) disable iff (RST)
    frame_wrap |=> TONE_REQ && TONE_RIDX == 5'h00)
    else $error("frame does not start with tone 0");

  // Middle clock rises as its divider wraps
  a_mid_clk_edge: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(BUS_CLKS.mid_clk) |-> mid_cnt == 7'h00)
    else $error("160 kHz clock rise off divider wrap");

  // Slot divider never leaves its ten states
  a_sub_range: assert property (@(posedge REF_CLK) disable iff (RST)
    sub_cnt <= `TCG_SLOT_LAST)
    else $error("slot divider out of range");

  // Bus output changes only at slot boundaries
  a_slot_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    !slot_end |=> $stable(BUS_OE_N) && $stable(BUS_DATA))
    else $error("bus output changed inside a slot");

  // Entry of the next slot is taken at the lead fetch edge
  a_lead_fetch: assert property (@(posedge REF_CLK) disable iff (RST)
    fetch_now |=> entry_q == $past(tbl[next_slot]))
    else $error("table entry not fetched ahead");

endmodule // tcg_top
